// ---- hdl/psd_curve_lut.sv ----
// Intensity code to percent lookup with registered output
`timescale 1ns/100ps
`default_nettype none
module psd_curve_lut (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   input wire logic [2:0] code_i,
   input wire logic log_sel_i,
   output logic [6:0] pct_o
);
   import psd_pkg::*;
   logic [6:0] pct_q;
   logic [6:0] pct_d;

   always_comb begin
      if (clr_i) begin
         pct_d = 7'h00;
      end else if (log_sel_i) begin
         pct_d = PSD_LOG_PCT[code_i];
      end else begin
         pct_d = PSD_LIN_PCT[code_i];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pct_q <= 7'h00;
      end else begin
         pct_q <= pct_d;
      end
   end

   assign pct_o = pct_q;

   property p_curve_point;
      @(posedge clk_i) disable iff (rst_i)
         (!clr_i && code_i == 3'h4) |=> (pct_q == ($past(log_sel_i) ? 7'd10 : 7'd32));
   endproperty
   curve_point_a: assert property (p_curve_point) else $error("curve value wrong");
endmodule
`default_nettype wire

// ---- hdl/psd_step_decoder.sv ----
// Pattern step decoder: duration, blue intensity and ramp engine
//
// Operation
// - Duration code: upper bits from word A bits 1-0, lower from word B 7-6.
// - Each step runs 197 ms to 3146 ms as the duration code selects.
// - Blue code is word B bits 5-3; code zero gives zero current.
// - Linear curve maps codes 1..7 to 7,14,21,32,46,71,100 percent.
// - Log curve maps codes 1..7 to 1,2,4,10,21,46,100 percent.
// - Ramp code is word B bits 2-0, selecting 0 to 3539 ms.
// - Any write to the reset register returns the block to reset state.
`timescale 1ns/100ps
`default_nettype none
module psd_step_decoder #(
   parameter int TICK_CYCLES = psd_pkg::PSD_TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic log_curve_i,
   output logic [7:0] reg_rdata_o,
   output logic [3:0] cet_code_o,
   output logic [2:0] ramp_time_code_o,
   output logic [6:0] blue_level_o,
   output logic step_active_o,
   output logic ramping_o,
   output logic step_done_o
);
   import psd_pkg::*;

   logic [7:0] word_a_q, word_a_d, word_b_q, word_b_d, rdata_q, rdata_d;
   logic srst_q, srst_d;
   logic [1:0] start_q, start_d;
   logic log_s1_q, log_s2_q;
   psd_state_e state_q, state_d;
   logic [17:0] tick_q, tick_d;
   logic [11:0] ms_q, ms_d, dur_q, dur_d, ramp_q, ramp_d, acc_q, acc_d;
   logic [6:0] level_q, level_d, target_q, target_d, lut_pct, delta;
   logic [6:0] span_q, span_d;
   logic done_q, done_d;
   logic active_q, active_d, ramp_flag_q, ramp_flag_d;
   logic tick;
   logic [3:0] cet_code;
   logic [2:0] blue_code, ramp_code;

   assign cet_code = {word_a_q[PSD_A_CET_HI:PSD_A_CET_LO], word_b_q[PSD_B_CET_HI:PSD_B_CET_LO]};
   assign blue_code = word_b_q[PSD_B_BLUE_HI:PSD_B_BLUE_LO];
   assign ramp_code = word_b_q[PSD_B_RAMP_HI:PSD_B_RAMP_LO];
   assign tick = (tick_q == 18'(TICK_CYCLES - 1));
   // Distance from the present level to the level the new step asks for
   assign delta = (lut_pct > level_q) ? 7'(lut_pct - level_q) : 7'(level_q - lut_pct);

   psd_curve_lut u_lut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(srst_q),
      .code_i(blue_code),
      .log_sel_i(log_s2_q),
      .pct_o(lut_pct)
   );

   // Register file and reads
   always_comb begin
      word_a_d = word_a_q;
      word_b_d = word_b_q;
      srst_d = 1'b0;
      start_d = {start_q[0], 1'b0};
      rdata_d = 8'h00;
      if (srst_q) begin
         word_a_d = PSD_STEP_RST;
         word_b_d = PSD_STEP_RST;
         start_d = 2'h0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == PSD_ADDR_STEP_A) begin
            word_a_d = reg_wdata_i;
         end else if (reg_addr_i == PSD_ADDR_STEP_B) begin
            word_b_d = reg_wdata_i;
            start_d[0] = 1'b1;
         end else if (reg_addr_i == PSD_ADDR_RESET) begin
            srst_d = 1'b1;
         end
      end
      if (reg_addr_i == PSD_ADDR_STEP_A) begin
         rdata_d = word_a_q;
      end else if (reg_addr_i == PSD_ADDR_STEP_B) begin
         rdata_d = word_b_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         word_a_q <= 8'h00;
         word_b_q <= 8'h00;
         srst_q <= 1'b0;
         start_q <= 2'h0;
         rdata_q <= 8'h00;
         log_s1_q <= 1'b0;
         log_s2_q <= 1'b0;
      end else begin
         word_a_q <= word_a_d;
         word_b_q <= word_b_d;
         srst_q <= srst_d;
         start_q <= start_d;
         rdata_q <= rdata_d;
         log_s1_q <= log_curve_i;
         log_s2_q <= log_s1_q;
      end
   end

   // Step timer and ramp engine
   always_comb begin
      state_d = state_q;
      tick_d = tick ? 18'h0 : 18'(tick_q + 18'h1);
      ms_d = tick ? 12'(ms_q + 12'h1) : ms_q;
      dur_d = dur_q;
      ramp_d = ramp_q;
      acc_d = acc_q;
      level_d = level_q;
      target_d = target_q;
      span_d = span_q;
      done_d = 1'b0;
      if (srst_q) begin
         state_d = PSD_IDLE;
         tick_d = 18'h0;
         ms_d = 12'h0;
         dur_d = 12'h0;
         ramp_d = 12'h0;
         acc_d = 12'h0;
         level_d = 7'h00;
         target_d = 7'h00;
         span_d = 7'h00;
      end else if (start_q[1]) begin
         state_d = PSD_RAMP;
         tick_d = 18'h0;
         ms_d = 12'h0;
         acc_d = 12'h0;
         dur_d = PSD_CET_MS[cet_code];
         ramp_d = PSD_RAMP_MS[ramp_code];
         target_d = lut_pct;
         // Fixed span keeps the ramp rate constant while the level moves
         span_d = delta;
      end else begin
         case (state_q)
            PSD_RAMP: begin
               // Spread the change evenly over the ramp
               if (ms_q >= ramp_q || ms_q >= dur_q) begin
                  level_d = target_q;
                  state_d = PSD_HOLD;
               end else begin
                  acc_d = tick ? 12'(acc_q + {5'h0, span_q}) : acc_q;
                  if (acc_q >= ramp_q && level_q != target_q) begin
                     acc_d = 12'(acc_d - ramp_q);
                     level_d = (target_q > level_q) ? 7'(level_q + 7'h1) : 7'(level_q - 7'h1);
                  end
               end
            end
            PSD_HOLD: begin
               // Step ends once its duration has elapsed
               if (ms_q >= dur_q) begin
                  state_d = PSD_IDLE;
                  done_d = 1'b1;
               end
            end
            default: begin
               tick_d = 18'h0;
               ms_d = 12'h0;
            end
         endcase
      end
      active_d = (state_d != PSD_IDLE);
      ramp_flag_d = (state_d == PSD_RAMP);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= PSD_IDLE;
         tick_q <= 18'h0;
         ms_q <= 12'h0;
         dur_q <= 12'h0;
         ramp_q <= 12'h0;
         acc_q <= 12'h0;
         level_q <= 7'h00;
         target_q <= 7'h00;
         done_q <= 1'b0;
         span_q <= 7'h00;
         active_q <= 1'b0;
         ramp_flag_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tick_q <= tick_d;
         ms_q <= ms_d;
         dur_q <= dur_d;
         ramp_q <= ramp_d;
         acc_q <= acc_d;
         level_q <= level_d;
         target_q <= target_d;
         done_q <= done_d;
         span_q <= span_d;
         active_q <= active_d;
         ramp_flag_q <= ramp_flag_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign cet_code_o = {word_a_q[1:0], word_b_q[7:6]};
   assign ramp_time_code_o = word_b_q[2:0];
   assign blue_level_o = level_q;
   assign step_active_o = active_q;
   assign ramping_o = ramp_flag_q;
   assign step_done_o = done_q;

   sequence s_write_b;
      reg_wr_i && reg_addr_i == PSD_ADDR_STEP_B && !srst_q;
   endsequence
   sequence s_step_begins;
      ##3 (state_q == PSD_RAMP && ms_q == 12'h0);
   endsequence

   step_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_write_b |-> s_step_begins) else $error("step did not start");
   dur_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      start_q[1] && !srst_q |=> dur_q == PSD_CET_MS[$past(cet_code)]) else $error("bad duration");
   cet_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == PSD_ADDR_STEP_B && !srst_q
      |=> cet_code_o[1:0] == $past(reg_wdata_i[7:6])) else $error("bad duration code");
   ramp_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
      start_q[1] && !srst_q |=> ramp_q == PSD_RAMP_MS[$past(ramp_time_code_o)])
      else $error("bad ramp time");
   zero_blue_a: assert property (@(posedge clk_i) disable iff (rst_i)
      start_q[1] && !srst_q && blue_code == 3'h0 && $stable(blue_code)
      |=> target_q == 7'h00) else $error("code zero not dark");
   soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == PSD_ADDR_RESET
      |=> ##1 (word_b_q == 8'h00 && state_q == PSD_IDLE && level_q == 7'h00))
      else $error("soft reset missed");
   hold_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == PSD_HOLD |-> level_q == target_q && level_q <= PSD_PCT_MAX)
      else $error("hold level wrong");
   done_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      done_q |-> $past(ms_q) >= $past(dur_q) && $past(state_q) == PSD_HOLD)
      else $error("step ended early");
endmodule
`default_nettype wire

// ---- pkg/psd_pkg.sv ----
// Constants for the pattern step decoder
package psd_pkg;
   // Register offsets
   localparam logic [7:0] PSD_ADDR_STEP_A = 8'h00;
   localparam logic [7:0] PSD_ADDR_STEP_B = 8'h01;
   localparam logic [7:0] PSD_ADDR_RESET = 8'h60;
   localparam logic [7:0] PSD_STEP_RST = 8'h00;
   // Field positions
   localparam int PSD_A_CET_HI = 1;
   localparam int PSD_A_CET_LO = 0;
   localparam int PSD_B_CET_HI = 7;
   localparam int PSD_B_CET_LO = 6;
   localparam int PSD_B_BLUE_HI = 5;
   localparam int PSD_B_BLUE_LO = 3;
   localparam int PSD_B_RAMP_HI = 2;
   localparam int PSD_B_RAMP_LO = 0;
   // Timing: one millisecond tick at a 5 ns clock
   localparam int PSD_CLK_PERIOD_NS = 5;
   localparam int PSD_TICK_NS = 1000000;
   localparam int PSD_TICK_CYCLES = PSD_TICK_NS / PSD_CLK_PERIOD_NS;
   localparam logic [6:0] PSD_PCT_MAX = 7'h64;
   // Step durations in ms per duration code
   localparam logic [11:0] PSD_CET_MS [16] = '{
      12'd197, 12'd393, 12'd590, 12'd786, 12'd983, 12'd1180, 12'd1376, 12'd1573,
      12'd1769, 12'd1966, 12'd2163, 12'd2359, 12'd2556, 12'd2753, 12'd2949, 12'd3146};
   // Ramp times in ms per ramp_time_code
   localparam logic [11:0] PSD_RAMP_MS [8] = '{
      12'd0, 12'd55, 12'd110, 12'd221, 12'd442, 12'd885, 12'd1770, 12'd3539};
   // Percent of maximum current per intensity code
   localparam logic [6:0] PSD_LIN_PCT [8] = '{
      7'd0, 7'd7, 7'd14, 7'd21, 7'd32, 7'd46, 7'd71, 7'd100};
   localparam logic [6:0] PSD_LOG_PCT [8] = '{
      7'd0, 7'd1, 7'd2, 7'd4, 7'd10, 7'd21, 7'd46, 7'd100};
   typedef enum logic [1:0] {PSD_IDLE, PSD_RAMP, PSD_HOLD} psd_state_e;
endpackage

// ---- verification/psd_host_model.sv ----
// Host model driving the register strobe, address and write data
`timescale 1ns/100ps
`default_nettype none
module psd_host_model (
   input wire logic clk_i,
   output logic reg_wr_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o
);
   import psd_pkg::*;
   initial begin
      reg_wr_o = 1'b0;
      reg_addr_o = 8'h7F;
      reg_wdata_o = 8'h00;
   end
   // One strobe cycle per write; released data is inverted, not left stale
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~data;
   endtask
   task automatic soft_reset(input logic [7:0] data);
      write(PSD_ADDR_RESET, data);
   endtask
   task automatic put_addr(input logic [7:0] addr);
      @(posedge clk_i);
      reg_addr_o <= addr;
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_psd_step_decoder.sv ----
// Self-checking bench for the pattern step decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_psd_step_decoder;
   import psd_pkg::*;
   localparam int T = 10;
   typedef struct {logic [3:0] cet; logic [2:0] rc; logic [6:0] pct; int dur; int rmp;} psd_exp_s;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic log_curve_i = 1'b0;
   logic rd_chk = 1'b0;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata_o;
   logic [3:0] cet_code_o;
   logic [2:0] ramp_time_code_o;
   logic [6:0] blue_level_o;
   logic step_active_o;
   logic ramping_o;
   logic step_done_o;
   int num_errors = 0;
   int cmp_count = 0;
   int dur_n = 0;
   int rmp_n = 0;
   int unsigned seed_v;
   psd_exp_s step_q[$];
   logic [7:0] rd_q[$];
   always #2.5 clk_i = ~clk_i;
   psd_step_decoder #(.TICK_CYCLES(T)) psd_step_decoder_inst (.clk_i(clk_i), .rst_i(rst_i),
      .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .log_curve_i(log_curve_i), .reg_rdata_o(reg_rdata_o), .cet_code_o(cet_code_o),
      .ramp_time_code_o(ramp_time_code_o), .blue_level_o(blue_level_o),
      .step_active_o(step_active_o), .ramping_o(ramping_o), .step_done_o(step_done_o));
   psd_host_model psd_host_model_inst (.clk_i(clk_i), .reg_wr_o(reg_wr),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
   // Scoreboard: reads and finished steps are compared with the oldest note
   always @(negedge clk_i) begin
      psd_exp_s e;
      if (rd_chk) begin
         `CHK(reg_rdata_o, rd_q.pop_front())
      end
      if (step_done_o === 1'b1) begin
         e = step_q.pop_front();
         `CHK(cet_code_o, e.cet)
         `CHK(ramp_time_code_o, e.rc)
         `CHK(blue_level_o, e.pct)
         `CHK(dur_n >= e.dur * T && dur_n <= e.dur * T + T + 6, 1'b1)
         `CHK(rmp_n >= e.rmp * T && rmp_n <= e.rmp * T + T + 6, 1'b1)
      end
      dur_n = (step_active_o === 1'b1) ? dur_n + 1 : 0;
      rmp_n = (step_active_o === 1'b1) ? rmp_n + int'(ramping_o === 1'b1) : 0;
   end
   task automatic results();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
      psd_host_model_inst.put_addr(addr);
      rd_q.push_back(exp);
      @(posedge clk_i);
      rd_chk <= 1'b1;
      @(posedge clk_i);
      rd_chk <= 1'b0;
   endtask
   task automatic run_step(input logic [3:0] cet, input logic [2:0] code, input logic [2:0] rc,
      input logic lg);
      logic [7:0] a;
      logic [7:0] b;
      psd_exp_s e;
      int n;
      log_curve_i <= lg;
      a = {6'($urandom()), cet[3:2]};
      b = {cet[1:0], code, rc};
      e.cet = cet;
      e.rc = rc;
      e.pct = lg ? PSD_LOG_PCT[code] : PSD_LIN_PCT[code];
      e.dur = int'(PSD_CET_MS[cet]);
      e.rmp = int'(PSD_RAMP_MS[rc]) < e.dur ? int'(PSD_RAMP_MS[rc]) : e.dur;
      step_q.push_back(e);
      psd_host_model_inst.write(PSD_ADDR_STEP_A, a);
      psd_host_model_inst.write(PSD_ADDR_STEP_B, b);
      n = 0;
      while (step_done_o !== 1'b1 && n < 40000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 40000) begin
         num_errors++;
      end
      read_chk(PSD_ADDR_STEP_A, a);
      read_chk(PSD_ADDR_STEP_B, b);
   endtask
   initial begin
      seed_v = $urandom(67582);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      read_chk(PSD_ADDR_STEP_A, 8'h00);
      read_chk(PSD_ADDR_STEP_B, 8'h00);
      read_chk(PSD_ADDR_RESET, 8'h00);
      psd_host_model_inst.write(8'h02, 8'($urandom()));
      read_chk(8'h02, 8'h00);
      for (int c = 0; c < 16; c++) begin
         run_step(4'h0, c[2:0], 3'($urandom()), c[3]);
      end
      run_step(4'hF, 3'h7, 3'h7, 1'b0);
      run_step(4'($urandom()) & 4'h7, 3'($urandom()), 3'h1, 1'b1);
      psd_host_model_inst.write(PSD_ADDR_STEP_A, 8'h03);
      psd_host_model_inst.write(PSD_ADDR_STEP_B, 8'hFF);
      repeat (100) @(negedge clk_i);
      `CHK(step_active_o, 1'b1)
      psd_host_model_inst.soft_reset(8'($urandom()));
      repeat (3) @(negedge clk_i);
      `CHK(step_active_o, 1'b0)
      `CHK(blue_level_o, 7'h00)
      `CHK(cet_code_o, 4'h0)
      read_chk(PSD_ADDR_STEP_B, 8'h00);
      results();
   end
   initial begin
      #(95000 * 5);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
